// [rtl/fal_pkg.sv]
// Package with the register map, field layout and carrier types of the fault alarm logic.
package fal_pkg;
  // Register offsets as seen through the serial programming port.
  localparam logic [6:0] OFF_OVD_UPPER = 7'h0c;
  localparam logic [6:0] OFF_OVD_LOWER = 7'h0d;
  localparam logic [6:0] OFF_FAULT_MASK = 7'h1d;
  localparam logic [6:0] OFF_FAULT_STATUS = 7'h1e;
  // Field positions shared by the mask and status registers.
  localparam int BIT_OVD = 0;
  localparam int BIT_CLAMP = 2;
  localparam int BIT_THERM = 3;
  localparam int TRIP_LSB = 4;
  localparam int TRIP_MSB = 6;
  // Writable bits per channel; channel 1 has no thermal fields.
  localparam logic [7:0] MASK_BITS_CH0 = 8'h7d;
  localparam logic [7:0] MASK_BITS_CH1 = 8'h05;
  // Reset values: overvoltage and clamp masked, thermal enabled, lowest trip point.
  localparam logic [7:0] MASK_RESET = 8'h05;
  localparam logic [15:0] OVD_UPPER_RESET = 16'hffff;
  localparam logic [15:0] OVD_LOWER_RESET = 16'h0000;
  localparam int NUM_CH = 2;

  // One register access from the serial port decoder.
  typedef struct packed {
    logic wr;
    logic rd;
    logic ch;
    logic [6:0] addr;
    logic [15:0] wdata;
  } fal_req_s;

  // Raw fault inputs of one channel.
  typedef struct packed {
    logic [15:0] pin_level;
    logic clamp_active;
  } fal_src_s;

  // Complete state of the block.
  typedef struct packed {
    logic [1:0][7:0] mask;
    logic [1:0][7:0] status;
    logic [15:0] ovd_upper;
    logic [15:0] ovd_lower;
    logic [15:0] rdata;
    logic rvalid;
    logic alarm_drive;
  } fal_state_s;
endpackage

// [rtl/fal_fault_alarm_logic.sv]
// Fault alarm aggregation: per-channel sources, sticky status, masks and the alarm pin.
`timescale 1ns/100ps
// Notes on behaviour
// - Overvoltage and clamp per channel, one thermal.
// - Status at 0x1E read-only, cleared by read.
// - All unmasked faults combine onto one open-drain pin.
// - Reset: thermal enabled, overvoltage and clamp masked.
// - Faults only set status and the pin.
// - Bit 0 masks overvoltage; ch0 bit 3 thermal.
// - Bit 2 masks each channel's clamp alarm.
// - Ch0 bits 6:4 pick trip; flags sticky.
// - Shared window limits at 0x0C/0x0D on ch0.
module fal_fault_alarm_logic (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Register access from the serial port decoder.
  input wire fal_pkg::fal_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Fault sources.
  input wire fal_pkg::fal_src_s [1:0] src,
  input wire logic thermal_hot,
  output logic [2:0] thermal_trip_select,
  // Open-drain alarm pin.
  output logic alarm_o,
  output logic alarm_oe
);
  fal_pkg::fal_state_s st;
  fal_pkg::fal_state_s next_st;
  logic [1:0][7:0] fault_set;
  logic [1:0] status_read;
  logic any_unmasked;

  // Source detection: window comparison against shared limits and raw indicators.
  always_comb
  begin
    for (int c = 0; c < fal_pkg::NUM_CH; c++)
    begin
      fault_set[c] = 8'h00;
      fault_set[c][fal_pkg::BIT_OVD] = (src[c].pin_level > st.ovd_upper) ||
                                       (src[c].pin_level < st.ovd_lower);
      fault_set[c][fal_pkg::BIT_CLAMP] = src[c].clamp_active;
    end
    fault_set[0][fal_pkg::BIT_THERM] = thermal_hot;
  end

  // A read of the status register clears it for the addressed channel only.
  always_comb
  begin
    for (int c = 0; c < fal_pkg::NUM_CH; c++)
    begin
      status_read[c] = req.rd && (req.ch == c[0]) && (req.addr == fal_pkg::OFF_FAULT_STATUS);
    end
  end

  // The pin only reflects unmasked flags; masked sources still latch for polling.
  always_comb
  begin
    any_unmasked = 1'b0;
    for (int c = 0; c < fal_pkg::NUM_CH; c++)
    begin
      any_unmasked = any_unmasked | |(st.status[c] & ~st.mask[c]);
    end
  end

  // Next state of the whole block.
  always_comb
  begin
    next_st = st;
    next_st.rvalid = req.rd;
    next_st.rdata = 16'h0000;
    for (int c = 0; c < fal_pkg::NUM_CH; c++)
    begin
      // New faults win over a clear in the same cycle, so no event is lost.
      next_st.status[c] = (status_read[c] ? 8'h00 : st.status[c]) | fault_set[c];
    end
    if (req.wr)
    begin
      // The status register is read-only; writes to it fall through unmatched.
      case (req.addr)
        fal_pkg::OFF_FAULT_MASK:
        begin
          next_st.mask[req.ch] = req.wdata[7:0] &
            (req.ch ? fal_pkg::MASK_BITS_CH1 : fal_pkg::MASK_BITS_CH0);
        end
        fal_pkg::OFF_OVD_UPPER:
        begin
          if (!req.ch)
          begin
            next_st.ovd_upper = req.wdata;
          end
        end
        fal_pkg::OFF_OVD_LOWER:
        begin
          if (!req.ch)
          begin
            next_st.ovd_lower = req.wdata;
          end
        end
        default:
        begin
          next_st.ovd_upper = st.ovd_upper;
        end
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        fal_pkg::OFF_FAULT_MASK: next_st.rdata = {8'h00, st.mask[req.ch]};
        fal_pkg::OFF_FAULT_STATUS: next_st.rdata = {8'h00, st.status[req.ch]};
        fal_pkg::OFF_OVD_UPPER: next_st.rdata = req.ch ? 16'h0000 : st.ovd_upper;
        fal_pkg::OFF_OVD_LOWER: next_st.rdata = req.ch ? 16'h0000 : st.ovd_lower;
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Nothing else reacts to a fault; the pin is the only action taken.
    next_st.alarm_drive = any_unmasked;
  end

  // State register.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st.mask <= {fal_pkg::MASK_RESET, fal_pkg::MASK_RESET};
      st.status <= 16'h0000;
      st.ovd_upper <= fal_pkg::OVD_UPPER_RESET;
      st.ovd_lower <= fal_pkg::OVD_LOWER_RESET;
      st.rdata <= 16'h0000;
      st.rvalid <= 1'b0;
      st.alarm_drive <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs; the pin only ever pulls low, the enable carries the alarm.
  assign rdata = st.rdata;
  assign rvalid = st.rvalid;
  assign thermal_trip_select = st.mask[0][fal_pkg::TRIP_MSB:fal_pkg::TRIP_LSB];
  assign alarm_o = 1'b0;
  assign alarm_oe = st.alarm_drive;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_status_read0;
    req.rd && !req.ch && req.addr == fal_pkg::OFF_FAULT_STATUS;
  endsequence

  sequence s_quiet_thermal;
    !thermal_hot;
  endsequence

  a_read_clears_thermal: assert property ((s_status_read0 and s_quiet_thermal) |=>
    !st.status[0][fal_pkg::BIT_THERM])
    else $error("Status read did not clear thermal flag.");
  a_read_returns_status: assert property (s_status_read0 |=>
    rvalid && rdata[7:0] == $past(st.status[0]))
    else $error("Status read returned wrong data.");
  a_flag_sticky: assert property (st.status[1][fal_pkg::BIT_CLAMP] &&
    !(req.rd && req.ch && req.addr == fal_pkg::OFF_FAULT_STATUS) |=>
    st.status[1][fal_pkg::BIT_CLAMP])
    else $error("Clamp flag dropped without a read.");
  a_set_beats_clear: assert property ((s_status_read0 and thermal_hot) |=>
    st.status[0][fal_pkg::BIT_THERM])
    else $error("Thermal event lost during clear.");
  a_thermal_alarm_path: assert property (thermal_hot && !st.mask[0][fal_pkg::BIT_THERM] |=>
    ##1 alarm_oe && !alarm_o)
    else $error("Thermal fault did not pull the alarm pin.");
  a_ovd_window_set: assert property (src[0].pin_level > st.ovd_upper |=>
    st.status[0][fal_pkg::BIT_OVD])
    else $error("Upper window breach not latched.");
  a_clamp_set: assert property (src[1].clamp_active |=>
    st.status[1][fal_pkg::BIT_CLAMP])
    else $error("Clamp indicator not latched.");
  a_masked_no_alarm: assert property ((st.status & ~st.mask) == 16'h0000 |=> !alarm_oe)
    else $error("Alarm pin driven with no unmasked flag.");
  a_alarm_released: assert property ($fell(any_unmasked) |=> !alarm_oe)
    else $error("Alarm pin held after flags cleared.");
  a_mask_after_reset: assert property ($rose(rstn) |->
    st.mask[0] == fal_pkg::MASK_RESET && st.mask[1] == fal_pkg::MASK_RESET)
    else $error("Mask register wrong after reset.");
  a_status_readonly: assert property (req.wr && req.addr == fal_pkg::OFF_FAULT_STATUS &&
    !req.rd && st.status[0][fal_pkg::BIT_OVD] |=> st.status[0][fal_pkg::BIT_OVD])
    else $error("Write altered the status register.");
  a_ch1_no_thermal: assert property (st.mask[1][fal_pkg::TRIP_MSB:fal_pkg::BIT_THERM] == 4'h0 &&
    st.status[1][fal_pkg::BIT_THERM] == 1'b0)
    else $error("Channel 1 holds thermal fields.");
  a_no_other_action: assert property (thermal_trip_select ==
    st.mask[0][fal_pkg::TRIP_MSB:fal_pkg::TRIP_LSB] && alarm_o == 1'b0)
    else $error("Fault altered something besides status and pin.");
endmodule

// [verif/test_fault_alarm_logic.sv]
// Self-checking testbench of the fault alarm logic.
`timescale 1ns/100ps
`define chk(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module test_fault_alarm_logic;
  // Design ports; pins sit inside the window until a test moves them.
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  fal_pkg::fal_req_s req = '0;
  fal_pkg::fal_src_s [1:0] src = {17'h08000, 17'h08000};
  logic thermal_hot = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic [2:0] thermal_trip_select;
  logic alarm_o;
  logic alarm_oe;
  int n_fail = 0;
  int samples_checked = 0;
  // One access per row: write flag, channel, offset, and the word written or expected.
  typedef struct packed {logic wr; logic ch; logic [6:0] a; logic [15:0] d;} fal_row_s;
  fal_row_s rows [15] = '{
    {2'b00, 7'h1d, 16'h0005}, {2'b01, 7'h1d, 16'h0005}, {2'b00, 7'h0c, 16'hffff},
    {2'b00, 7'h0d, 16'h0000}, {2'b00, 7'h1e, 16'h0000}, {2'b10, 7'h1d, 16'h007f},
    {2'b00, 7'h1d, 16'h007d}, {2'b11, 7'h1d, 16'h00ff}, {2'b01, 7'h1d, 16'h0005},
    {2'b10, 7'h0c, 16'h8000}, {2'b11, 7'h0c, 16'h1234}, {2'b00, 7'h0c, 16'h8000},
    {2'b10, 7'h1e, 16'h00ff}, {2'b00, 7'h1e, 16'h0000}, {2'b00, 7'h10, 16'h0000}};

  fal_fault_alarm_logic u_fal_fault_alarm_logic (
    .mclk(mclk), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid), .src(src),
    .thermal_hot(thermal_hot), .thermal_trip_select(thermal_trip_select),
    .alarm_o(alarm_o), .alarm_oe(alarm_oe));

  // Free-running 100 ns clock.
  always #50 mclk = ~mclk;

  // Waits n edges and lands 10 ns after the last one, where outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask

  // One access, then an idle cycle so the strobe is never raised twice in one step.
  task automatic acc(input logic wr, input logic ch, input logic [6:0] a, input logic [15:0] d);
    req = '{wr: wr, rd: !wr, ch: ch, addr: a, wdata: d};
    tick(1);
    `chk("rvalid", !wr, rvalid)
    if (!wr)
      `chk("rdata", d, rdata)
    req = '0;
    tick(1);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog sized well beyond the fewer than a hundred cycles the tests need.
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end

  // Main sequence: reset, table of accesses, then fault paths by hand.
  initial
  begin
    repeat (16) @(posedge mclk);
    `chk("alarm_oe", 1'b0, alarm_oe)
    #10 rstn = 1'b1;
    tick(1);
    foreach (rows[i]) acc(rows[i].wr, rows[i].ch, rows[i].a, rows[i].d);
    `chk("trip", 3'h7, thermal_trip_select)
    acc(1'b1, 1'b0, 7'h1d, 16'h0000);
    thermal_hot = 1'b1;
    tick(1);
    thermal_hot = 1'b0;
    `chk("alarm_oe", 1'b0, alarm_oe)
    tick(1);
    `chk("alarm_oe", 1'b1, alarm_oe)
    `chk("alarm_o", 1'b0, alarm_o)
    tick(3);
    `chk("alarm_oe", 1'b1, alarm_oe)
    acc(1'b0, 1'b0, 7'h1e, 16'h0008);
    `chk("alarm_oe", 1'b0, alarm_oe)
    acc(1'b0, 1'b0, 7'h1e, 16'h0000);
    // A masked clamp fault latches but leaves the pin alone.
    src[1].clamp_active = 1'b1;
    tick(1);
    src[1].clamp_active = 1'b0;
    tick(2);
    `chk("alarm_oe", 1'b0, alarm_oe)
    acc(1'b0, 1'b1, 7'h1e, 16'h0004);
    // Unmasked overvoltage above the shared upper limit on channel 1.
    acc(1'b1, 1'b1, 7'h1d, 16'h0000);
    src[1].pin_level = 16'h9000;
    tick(1);
    src[1].pin_level = 16'h4000;
    tick(1);
    `chk("alarm_oe", 1'b1, alarm_oe)
    acc(1'b0, 1'b1, 7'h1e, 16'h0001);
    // Below the lower limit together with a clamp on channel 0.
    acc(1'b1, 1'b0, 7'h0d, 16'h1000);
    src[0] = {16'h0fff, 1'b1};
    tick(1);
    src[0] = {16'h4000, 1'b0};
    acc(1'b0, 1'b0, 7'h1e, 16'h0005);
    // Reset in mid-run with a flag latched must drop the pin and restore masks.
    thermal_hot = 1'b1;
    tick(3);
    thermal_hot = 1'b0;
    rstn = 1'b0;
    #10;
    `chk("alarm_oe", 1'b0, alarm_oe)
    `chk("trip", 3'h0, thermal_trip_select)
    tick(2);
    rstn = 1'b1;
    tick(1);
    acc(1'b0, 1'b0, 7'h1d, 16'h0005);
    acc(1'b0, 1'b0, 7'h1e, 16'h0000);
    stop_test();
  end
endmodule
